// ---- src/bsp_consts.vh ----
// Constants for the clock-stop serial port: register map, fields, resets.
// Assumes a 200 MHz APB clock and 32-bit aligned register words.
`ifndef BSP_CONSTS_VH
`define BSP_CONSTS_VH

// ============================================================
// Register byte offsets
`define BSP_CTRL_OFF 12'h000
`define BSP_DIV_OFF 12'h004
`define BSP_TXD_OFF 12'h008
`define BSP_RXD_OFF 12'h00c
`define BSP_STAT_OFF 12'h010

// ============================================================
// Control fields
`define BSP_CTRL_EN 0
`define BSP_CTRL_MASTER 1
`define BSP_CTRL_CSTP_LO 2
`define BSP_CTRL_CSTP_HI 3
`define BSP_CTRL_TXPOL 4
`define BSP_CTRL_SRCSEL 5
`define BSP_CTRL_TXSPOL 6
`define BSP_CTRL_RXSPOL 7
`define BSP_CTRL_TXCDIR 8
`define BSP_CTRL_RXCDIR 9
`define BSP_CTRL_TXSDIR 10
`define BSP_CTRL_RXSDIR 11
`define BSP_CTRL_W 12

// Reset values: clock-stop 11b, polarities 1, slave, divider 1 from pclk
`define BSP_CTRL_RST 12'h0fc
`define BSP_DIV_RST 8'h01

// ============================================================
// Word size and modes
`define BSP_WORD_W 8
`define BSP_BITCNT_W 4
`define BSP_MODE_10 2'b10
`define BSP_MODE_11 2'b11

// ============================================================
// Timing: fastest allowed bit rate and the clock it is measured against
`define BSP_PCLK_MHZ 200
`define BSP_MAX_RATE_MHZ 100
`define BSP_MIN_DIV ((`BSP_PCLK_MHZ + `BSP_MAX_RATE_MHZ - 1) / \
	`BSP_MAX_RATE_MHZ - 1)

`endif

// ---- src/bsp_sync.v ----
// Two-flop synchroniser for one level input.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
module bsp_sync (
	input wire pclk,
	input wire presetn,
	input wire din,
	output reg dout
);
	reg meta_reg;

	// First stage feeds only the second stage, nothing else
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

// ---- src/bsp_spi.v ----
// Clock-stop serial port in SPI-compatible mode, master or slave, with an
// APB register slave. Assumes pins are external and synchronous enough
// to pclk for the external divider clock; slave clock and select pins are synchronised.
`timescale 1ns/1ps
`include "bsp_consts.vh"

// Notes on behaviour
// - Bit period is source period times div+1
// - High phase: div/2+1 even, (div+1)/2 odd
// - Low phase: div/2 even, (div+1)/2 odd
// - Divider source is pclk or external pin
// - Slave runs divider at half pclk
// - Master drives inverted, active-low select
// - Slave inverts both active-low select inputs
// - Master: transmit directions out, receive in
// - Slave: all clock and select directions in
// - Select low before enabling edge, then transfer
// - Divider keeps bit rate within maximum
// - Select leads first fall by half/one bit
// - Select holds after last rise: full/half
// - Mode 10b: output changes on falling edge
// - Mode 11b: output changes on rising edge
// - Mode 11b: input sampled on falling edge
// - Master output released after last rising edge
// - Slave 10b output released when select rises
// - Slave drives first bit soon after select falls
module bsp_spi (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_div_clock,
	input wire tx_bit_clock_in,
	output reg tx_bit_clock_out,
	output reg tx_bit_clock_oe,
	input wire tx_frame_sync_in,
	output reg tx_frame_sync_out,
	output reg tx_frame_sync_oe,
	input wire rx_frame_sync_in,
	output reg serial_data_out,
	output reg serial_data_oe,
	input wire serial_data_in
);
	// ============================================================
	// Registers
	reg [`BSP_CTRL_W-1:0] ctrl_reg;
	reg [7:0] div_reg;
	reg [`BSP_WORD_W-1:0] txd_reg;
	reg [`BSP_WORD_W-1:0] rxd_reg;
	reg start_reg;
	reg done_reg;
	reg rxfull_reg;
	reg busy_reg;
	reg [`BSP_WORD_W-1:0] sh_reg;
	reg [`BSP_WORD_W-1:0] rsh_reg;
	reg [`BSP_BITCNT_W-1:0] bit_reg;
	reg [7:0] ph_reg;
	reg [2:0] st_reg;
	reg ext_d_reg;
	reg sclk_d_reg;
	reg ssel_d_reg;

	wire en = ctrl_reg[`BSP_CTRL_EN];
	wire master = ctrl_reg[`BSP_CTRL_MASTER];
	wire [1:0] cstp = ctrl_reg[`BSP_CTRL_CSTP_HI:`BSP_CTRL_CSTP_LO];
	wire mode11 = (cstp == `BSP_MODE_11);
	wire acc = psel & penable;
	wire wr = acc & pwrite;

	// Config legal for the chosen role; otherwise the port stays idle
	wire cfg_master = ctrl_reg[`BSP_CTRL_TXCDIR] &
		ctrl_reg[`BSP_CTRL_TXSDIR] & ~ctrl_reg[`BSP_CTRL_RXCDIR] &
		~ctrl_reg[`BSP_CTRL_RXSDIR];
	wire cfg_slave = ~|ctrl_reg[`BSP_CTRL_RXSDIR:`BSP_CTRL_TXCDIR] &
		ctrl_reg[`BSP_CTRL_SRCSEL] & (div_reg == 8'h01);
	wire cfg_ok = ctrl_reg[`BSP_CTRL_TXPOL] & ctrl_reg[cstp[1] ?
		`BSP_CTRL_TXSPOL : `BSP_CTRL_TXSPOL] &
		ctrl_reg[`BSP_CTRL_RXSPOL] & cstp[1] &
		(master ? cfg_master : cfg_slave);
	wire run = en & cfg_ok;

	// ============================================================
	// Divider source: one-cycle enable per source clock period
	wire src_tick = ctrl_reg[`BSP_CTRL_SRCSEL] ? 1'b1 :
		(ext_div_clock & ~ext_d_reg);

	// Phase lengths from the divide value
	wire [7:0] hi_len = div_reg[0] ? ((div_reg >> 1) + 8'h01) :
		(div_reg == 8'h00 ? 8'h01 : (div_reg >> 1) + 8'h01);
	wire [7:0] lo_len = div_reg[0] ? ((div_reg >> 1) + 8'h01) :
		(div_reg == 8'h00 ? 8'h01 : (div_reg >> 1));
	// Even nonzero: hi+lo = div+1; odd: (div+1); zero: 1 each is a
	// clamp, since a zero-length phase is unrealisable

	// ============================================================
	// Slave inputs: synchronised, then edge-detected
	wire sclk_s;
	wire ssel_raw_s;
	wire rsel_raw_s;
	bsp_sync u_sync_clk (
		.pclk(pclk), .presetn(presetn),
		.din(tx_bit_clock_in), .dout(sclk_s)
	);
	// Selects are inverted at the pin so the flops reset to deselected;
	// otherwise a false select edge would follow every reset
	bsp_sync u_sync_sel (
		.pclk(pclk), .presetn(presetn),
		.din(~tx_frame_sync_in), .dout(ssel_raw_s)
	);
	bsp_sync u_sync_rsel (
		.pclk(pclk), .presetn(presetn),
		.din(~rx_frame_sync_in), .dout(rsel_raw_s)
	);
	// Either active-low select input enables the slave
	wire ssel = ssel_raw_s | rsel_raw_s;
	wire s_rise = sclk_s & ~sclk_d_reg;
	wire s_fall = ~sclk_s & sclk_d_reg;

	// ============================================================
	// Engine states: master sequence, plus ST_SLV for slave role
	localparam ST_IDLE = 3'd0;
	localparam ST_LEAD = 3'd1;
	localparam ST_LOW = 3'd2;
	localparam ST_HIGH = 3'd3;
	localparam ST_TAIL = 3'd4;
	localparam ST_SLV = 3'd5;

	wire [`BSP_BITCNT_W-1:0] last_bit = 4'h7; // Word size minus one
	wire ph_done = src_tick & (ph_reg == 8'h01);
	// Start only on a source tick, so the lead is whole source periods
	wire start_ok = start_reg & ~busy_reg & src_tick & run & master &
		(st_reg == ST_IDLE);

	// ============================================================
	// Transfer engine; clock idles high (polarity 1)
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= ST_IDLE;
			ph_reg <= 8'h00;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rsh_reg <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			rxfull_reg <= 1'b0;
			rxd_reg <= 8'h00;
			ext_d_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
			ssel_d_reg <= 1'b0;
			tx_bit_clock_out <= 1'b1;
			tx_bit_clock_oe <= 1'b0;
			tx_frame_sync_out <= 1'b1;
			tx_frame_sync_oe <= 1'b0;
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end else begin
			ext_d_reg <= ext_div_clock;
			sclk_d_reg <= sclk_s;
			ssel_d_reg <= ssel;
			// Done clears on status read, rxfull on data read; a new event wins over the clear
			if (acc & ~pwrite & (paddr == `BSP_STAT_OFF))
				done_reg <= 1'b0;
			if (acc & ~pwrite & (paddr == `BSP_RXD_OFF))
				rxfull_reg <= 1'b0;
			tx_bit_clock_oe <= run & master;
			tx_frame_sync_oe <= run & master;
			if (!run) begin
				st_reg <= ST_IDLE;
				busy_reg <= 1'b0;
				tx_bit_clock_out <= 1'b1;
				tx_frame_sync_out <= 1'b1;
				serial_data_oe <= 1'b0;
			end else begin
				case (st_reg)
				ST_IDLE: begin
					tx_bit_clock_out <= 1'b1;
					tx_frame_sync_out <= 1'b1;
					bit_reg <= 4'h0;
					if (!master) begin
						st_reg <= ST_SLV;
					end else if (start_ok) begin
						busy_reg <= 1'b1;
						sh_reg <= txd_reg;
						// Select low before first edge
						tx_frame_sync_out <= 1'b0;
						// 11b leads with one full bit
						ph_reg <= mode11 ? hi_len + lo_len :
							hi_len;
						st_reg <= ST_LEAD;
						if (mode11) begin
							serial_data_oe <= 1'b1;
							serial_data_out <= txd_reg[7];
						end
					end
				end
				ST_LEAD: if (src_tick) begin
					if (ph_done) begin
						tx_bit_clock_out <= 1'b0;
						ph_reg <= lo_len;
						st_reg <= ST_LOW;
						if (!mode11) begin
							// Data launched on the fall
							serial_data_oe <= 1'b1;
							serial_data_out <= sh_reg[7];
						end else begin
							// Input taken on the fall
							rsh_reg <= {rsh_reg[6:0],
								serial_data_in};
						end
					end else
						ph_reg <= ph_reg - 8'h01;
				end
				ST_LOW: if (src_tick) begin
					if (ph_done) begin
						tx_bit_clock_out <= 1'b1;
						ph_reg <= hi_len;
						if (!mode11)
							rsh_reg <= {rsh_reg[6:0],
								serial_data_in};
						if (bit_reg == last_bit) begin
							// Hold select: full bit / high phase
							ph_reg <= mode11 ? hi_len :
								hi_len + lo_len;
							st_reg <= ST_TAIL;
							if (mode11)
								serial_data_oe <= 1'b0;
						end else begin
							st_reg <= ST_HIGH;
							sh_reg <= {sh_reg[6:0], 1'b0};
							if (mode11)
								serial_data_out <=
									sh_reg[6];
						end
					end else
						ph_reg <= ph_reg - 8'h01;
				end
				ST_HIGH: if (src_tick) begin
					if (ph_done) begin
						tx_bit_clock_out <= 1'b0;
						ph_reg <= lo_len;
						bit_reg <= bit_reg + 4'h1;
						st_reg <= ST_LOW;
						if (!mode11)
							serial_data_out <= sh_reg[7];
						else
							rsh_reg <= {rsh_reg[6:0],
								serial_data_in};
					end else
						ph_reg <= ph_reg - 8'h01;
				end
				ST_TAIL: begin
					// Release (10b) one high phase plus one source period after last rise
					if (ph_done)
						serial_data_oe <= 1'b0;
					if (src_tick & (ph_reg == lo_len) & ~mode11)
						serial_data_oe <= 1'b0;
					if (src_tick) begin
						if (ph_done) begin
							tx_frame_sync_out <= 1'b1;
							st_reg <= ST_IDLE;
							busy_reg <= 1'b0;
							done_reg <= 1'b1;
							rxfull_reg <= 1'b1;
							rxd_reg <= rsh_reg;
						end else
							ph_reg <= ph_reg - 8'h01;
					end
				end
				ST_SLV: begin
					if (master)
						st_reg <= ST_IDLE;
					if (ssel & ~ssel_d_reg) begin
						// Drive first bit right after select falls
						serial_data_oe <= 1'b1;
						serial_data_out <= txd_reg[7];
						sh_reg <= txd_reg;
						bit_reg <= 4'h0;
						busy_reg <= 1'b1;
					end else if (!ssel) begin
						// Release once select returns high
						serial_data_oe <= 1'b0;
						busy_reg <= 1'b0;
					end else if ((mode11 ? s_fall : s_rise)) begin
						rsh_reg <= {rsh_reg[6:0],
							serial_data_in};
						bit_reg <= bit_reg + 4'h1;
						if (bit_reg == last_bit) begin
							done_reg <= 1'b1;
							rxfull_reg <= 1'b1;
							rxd_reg <= {rsh_reg[6:0],
								serial_data_in};
						end
					end else if ((mode11 ? s_rise : s_fall) &
						(bit_reg != 4'h0) &
						(bit_reg != `BSP_WORD_W)) begin
						sh_reg <= {sh_reg[6:0], 1'b0};
						serial_data_out <= sh_reg[6];
					end
				end
				default: st_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ============================================================
	// APB slave: zero wait states, errors on unmapped addresses
	wire mapped = (paddr == `BSP_CTRL_OFF) | (paddr == `BSP_DIV_OFF) |
		(paddr == `BSP_TXD_OFF) | (paddr == `BSP_RXD_OFF) |
		(paddr == `BSP_STAT_OFF);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `BSP_CTRL_RST;
			div_reg <= `BSP_DIV_RST;
			txd_reg <= 8'h00;
			start_reg <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (start_ok)
				start_reg <= 1'b0;
			if (wr & pready & (paddr == `BSP_CTRL_OFF))
				ctrl_reg <= pwdata[`BSP_CTRL_W-1:0];
			// Rate clamp keeps the bit clock within the maximum
			if (wr & pready & (paddr == `BSP_DIV_OFF))
				div_reg <= (pwdata[7:0] < `BSP_MIN_DIV) ?
					8'h01 : pwdata[7:0];
			if (wr & pready & (paddr == `BSP_TXD_OFF)) begin
				txd_reg <= pwdata[7:0];
				start_reg <= 1'b1;
			end
			if (psel & ~penable) begin
				case (paddr)
				`BSP_CTRL_OFF: prdata <= {20'h00000, ctrl_reg};
				`BSP_DIV_OFF: prdata <= {24'h000000, div_reg};
				`BSP_TXD_OFF: prdata <= {24'h000000, txd_reg};
				`BSP_RXD_OFF: prdata <= {24'h000000, rxd_reg};
				`BSP_STAT_OFF: prdata <= {29'h00000000,
					rxfull_reg, done_reg, busy_reg};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	// Slave role requires pclk source and divide 1: half pclk
endmodule

// ---- sim/bsp_spi_asserts.sv ----
// Checker for the clock-stop serial port, bound to its top module.
// Assumes config is only changed between frames, over APB.
`timescale 1ns/1ps
`include "bsp_consts.vh"
module bsp_spi_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire tx_bit_clock_out,
	input wire tx_bit_clock_oe,
	input wire tx_frame_sync_in,
	input wire tx_frame_sync_out,
	input wire tx_frame_sync_oe,
	input wire rx_frame_sync_in,
	input wire serial_data_out,
	input wire serial_data_oe
);
	reg [11:0] ctrl_q;
	reg [7:0] div_q;
	reg [7:0] lc;
	wire wr = psel && penable && pready && pwrite;
	wire mst = ctrl_q[1];
	wire m11 = ctrl_q[2];
	wire sel_n = tx_frame_sync_in && rx_frame_sync_in;
	wire slv = (ctrl_q == 12'h0fd || ctrl_q == 12'h0f9) && div_q == 8'h01;
	wire [7:0] d1 = (div_q < 8'h01) ? 8'h01 : div_q;
	wire [7:0] low = d1[0] ? (d1 + 8'h01) >> 1 : d1 >> 1;
	// ============================================================
	// Shadow of config, and width of the current low phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `BSP_CTRL_RST;
			div_q <= `BSP_DIV_RST;
			lc <= 8'h00;
		end else begin
			if (wr && paddr == `BSP_CTRL_OFF)
				ctrl_q <= pwdata[11:0];
			if (wr && paddr == `BSP_DIV_OFF)
				div_q <= pwdata[7:0];
			lc <= tx_bit_clock_out ? 8'h00 : lc + 8'h01;
		end
	end
	// ============================================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_setup_answer: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_dirs_paired: assert property (tx_bit_clock_oe == tx_frame_sync_oe)
		else $error("clock and select directions differ");
	a_idle_clock: assert property (tx_frame_sync_oe && tx_frame_sync_out |-> tx_bit_clock_out)
		else $error("clock low outside select");
	a_data_release: assert property (tx_frame_sync_oe && tx_frame_sync_out |-> !serial_data_oe)
		else $error("data driven outside select");
	a_low_phase: assert property ($rose(tx_bit_clock_out) && tx_bit_clock_oe && !tx_frame_sync_out && ctrl_q[5] |-> lc == low)
		else $error("low phase width wrong");
	a_chg_fall: assert property (mst && !m11 && serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out) |-> !tx_bit_clock_out)
		else $error("data changed in high phase");
	a_chg_rise: assert property (mst && m11 && serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out) |-> tx_bit_clock_out)
		else $error("data changed in low phase");
	a_slave_drive: assert property (slv && $fell(sel_n) |-> ##[1:6] serial_data_oe)
		else $error("slave data late");
	a_slave_release: assert property (slv && !m11 && $rose(sel_n) |-> ##[1:6] !serial_data_oe)
		else $error("slave data not released");
	c_master_frame: cover property ($fell(tx_frame_sync_out) && tx_frame_sync_oe);
	c_slave_frame: cover property (slv && $fell(sel_n));
	c_unmapped: cover property (pslverr);
endmodule
bind bsp_spi bsp_spi_asserts u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_bit_clock_out,
	.tx_bit_clock_oe, .tx_frame_sync_in, .tx_frame_sync_out,
	.tx_frame_sync_oe, .rx_frame_sync_in, .serial_data_out,
	.serial_data_oe);

// ---- sim/bsp_slave_model.sv ----
// Behavioural SPI peripheral facing the port in master role.
// Assumes clock idles high and select is active low.
`timescale 1ns/1ps
module bsp_slave_model (
	input wire sclk,
	input wire sel_n,
	input wire mosi,
	input wire mode11,
	input wire [7:0] tx_byte,
	output reg miso,
	output reg [7:0] rx_byte
);
	integer ec;
	integer k;
	initial miso = 1'h0;
	// First bit ready at select fall, before any clock edge
	always @(negedge sel_n) begin
		ec = 0;
		miso = tx_byte[7];
	end
	// Released line shows the inverse, never a held value
	always @(posedge sel_n)
		miso = ~miso;
	// Launch on one edge, capture on the other; 10b skips first fall
	always @(sclk) begin
		if (!sel_n && sclk === mode11) begin
			ec = ec + 1;
			k = mode11 ? 7 - ec : 8 - ec;
			if (k >= 0 && k < 7)
				miso = tx_byte[k];
		end else if (!sel_n)
			rx_byte = {rx_byte[6:0], mosi};
	end
endmodule

// ---- sim/tb_bsp_spi.sv ----
// Testbench for the clock-stop serial port: APB, master and slave frames.
// Assumes a partner peripheral model and a 200 MHz pclk.
`timescale 1ns/1ps
`include "bsp_consts.vh"
module tb_bsp_spi;
	reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	reg pwrite = 1'h0, ext_div_clock = 1'h0, sck = 1'h1, fs_tb = 1'h1;
	reg rfs = 1'h1, sdi_tb = 1'h0, m_mode = 1'h1;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg [7:0] m_byte = 8'h00;
	wire [31:0] prdata;
	wire pready, pslverr, clk_out, clk_oe, fs_out, fs_oe, sdo, sdo_oe, miso;
	wire [7:0] m_rx;
	// Two-way pins resolve from the enables
	wire sclk_w = clk_oe ? clk_out : sck;
	wire fs_w = fs_oe ? fs_out : fs_tb;
	wire sdi = clk_oe ? miso : sdi_tb;
	logic [31:0] rd;
	logic er;
	int fails = 0, checked = 0;
	// ============================================================
	// Clocks: pclk, and a divider source at a quarter of pclk
	always #2.5 pclk = ~pclk;
	always #10 ext_div_clock = ~ext_div_clock;
	bsp_spi dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_div_clock(ext_div_clock), .tx_bit_clock_in(sclk_w),
		.tx_bit_clock_out(clk_out), .tx_bit_clock_oe(clk_oe),
		.tx_frame_sync_in(fs_w), .tx_frame_sync_out(fs_out),
		.tx_frame_sync_oe(fs_oe), .rx_frame_sync_in(rfs),
		.serial_data_out(sdo), .serial_data_oe(sdo_oe), .serial_data_in(sdi));
	bsp_slave_model peer (.sclk(sclk_w), .sel_n(fs_w), .mosi(sdo),
		.mode11(m_mode), .tx_byte(m_byte), .miso(miso), .rx_byte(m_rx));
	// ============================================================
	// Shared tasks
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One APB transfer; idle cycle first so psel is never set twice at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20)
			fails++;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// ============================================================
	// Scenarios
	task regs;
		apb(0, `BSP_CTRL_OFF, 0);
		chk("ctrl reset", rd, 32'h0fc);
		apb(0, 12'h020, 0);
		chk("unmapped", er, 1);
		apb(1, `BSP_DIV_OFF, 0);
		apb(0, `BSP_DIV_OFF, 0);
		chk("div floor", rd, 1);
	endtask
	task master_xfer(input logic m11, input logic [7:0] dv, input logic src,
		input logic [7:0] b);
		int t, sf, f1, f2, r1, lr, sr, d, s, h, l;
		logic pc, pf;
		d = (dv < 1) ? 1 : dv;
		s = src ? 1 : 4;
		h = d[0] ? (d + 1) / 2 : d / 2 + 1;
		l = d[0] ? (d + 1) / 2 : d / 2;
		m_mode <= m11;
		m_byte <= ~b;
		apb(1, `BSP_DIV_OFF, dv);
		apb(1, `BSP_CTRL_OFF, 32'h5db | {26'h0, src, 2'h0, m11, 2'h0});
		apb(1, `BSP_TXD_OFF, b);
		{sf, f1, f2, r1, lr, sr} = {6{-32'sd1}};
		pc = 1'h1;
		pf = 1'h1;
		// Timestamp select fall and rise, first two clock falls, first and last clock rise
		for (t = 0; t < 600 && sr < 0; t++) begin
			@(posedge pclk);
			if (pf && !fs_w) sf = t;
			if (!pf && fs_w) sr = t;
			if (pc && !sclk_w && f1 >= 0 && f2 < 0) f2 = t;
			if (pc && !sclk_w && f1 < 0) f1 = t;
			if (!pc && sclk_w) lr = t;
			if (!pc && sclk_w && r1 < 0) r1 = t;
			pc = sclk_w;
			pf = fs_w;
		end
		chk("lead", f1 - sf, (m11 ? h + l : h) * s);
		chk("low", r1 - f1, l * s);
		chk("high", f2 - r1, h * s);
		chk("period", f2 - f1, (h + l) * s);
		chk("tail", sr - lr, (m11 ? h : h + l) * s);
		chk("mosi", m_rx, b);
		apb(0, `BSP_STAT_OFF, 0);
		chk("done", rd[1], 1);
		apb(0, `BSP_RXD_OFF, 0);
		chk("miso", rd[7:0], {24'h0, ~b});
	endtask
	task slave_xfer(input logic m11, input logic [7:0] b);
		int i;
		logic [7:0] got;
		apb(1, `BSP_DIV_OFF, 1);
		apb(1, `BSP_CTRL_OFF, m11 ? 32'h0fd : 32'h0f9);
		apb(1, `BSP_TXD_OFF, ~b);
		if (m11) fs_tb <= 1'h0;
		else rfs <= 1'h0;
		repeat (6) @(posedge pclk);
		// Bit clock at pclk/12, data launched opposite the sampling edge
		for (i = 7; i >= 0; i--) begin
			sdi_tb <= b[i];
			if (!m11) sck <= 1'h0;
			repeat (6) @(posedge pclk);
			if (!m11) got[i] = sdo;
			sck <= !m11;
			repeat (6) @(posedge pclk);
			if (m11) got[i] = sdo;
			if (m11) sck <= 1'h1;
		end
		repeat (6) @(posedge pclk);
		fs_tb <= 1'h1;
		rfs <= 1'h1;
		repeat (8) @(posedge pclk);
		chk("slave oe", sdo_oe, 0);
		chk("slave clk dir", clk_oe, 0);
		chk("slave out", got, {24'h0, ~b});
		apb(0, `BSP_RXD_OFF, 0);
		chk("slave in", rd[7:0], b);
	endtask
	task bad_cfg;
		apb(1, `BSP_CTRL_OFF, 32'h7ff);
		apb(1, `BSP_TXD_OFF, 32'h5a);
		repeat (30) @(posedge pclk);
		chk("bad master", fs_w, 1);
		chk("bad master oe", fs_oe, 0);
		apb(1, `BSP_DIV_OFF, 2);
		apb(1, `BSP_CTRL_OFF, 32'h0fd);
		fs_tb <= 1'h0;
		repeat (10) @(posedge pclk);
		chk("bad slave", sdo_oe, 0);
		fs_tb <= 1'h1;
	endtask
	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		regs;
		master_xfer(1, 3, 1, 8'ha5);
		master_xfer(0, 3, 1, 8'h3c);
		master_xfer(1, 2, 1, 8'h81);
		master_xfer(0, 4, 0, 8'h96);
		master_xfer(1, 0, 1, 8'h7e);
		slave_xfer(1, 8'hc3);
		slave_xfer(0, 8'h5a);
		bad_cfg;
		wrap_up;
	end
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
endmodule
